// ---- include/ecc_twi_pkg.sv ----
package ecc_twi_pkg;
  // ==========================================================
  // apb register map (byte addresses)
  localparam logic [7:0] OFF_EVENT_INFO = 8'h00;
  localparam logic [7:0] OFF_LOC1 = 8'h04;
  localparam logic [7:0] OFF_LOC2 = 8'h08;
  localparam logic [7:0] OFF_LOC3 = 8'h0C;
  localparam logic [7:0] OFF_LOC4 = 8'h10;
  localparam logic [7:0] OFF_SETTING = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_CTRL = 8'h1C;
  localparam logic [7:0] OFF_LAST = 8'h1C;

  // ==========================================================
  // setting register fields
  localparam int SET_ECCON = 0;
  localparam int SET_ERRON = 1;
  localparam int SET_CLEAR = 4;
  localparam logic [3:0] SET_KEEP_MASK = 4'hF;
  localparam logic [7:0] SETTING_RESET = 8'h00;

  // status register fields
  localparam int ST_EVENT = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_LATCH_LO = 2;
  localparam int ST_SELECTED = 5;

  // control register fields
  localparam int CTRL_ENABLE = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // ==========================================================
  // serial register addresses
  localparam logic [2:0] REG_FIRST = 3'b000;
  localparam logic [2:0] REG_LAST = 3'b101;
  localparam int NUM_REGS = 6;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] TYPE_BITS_TOP = 4'h7;

  // ==========================================================
  // timing: the port must keep up with the fast-plus rate
  localparam int CLK_KHZ = 25000;
  localparam int SCL_STD_FAST_KHZ = 400;
  localparam int SCL_FAST_PLUS_KHZ = 1000;
  localparam int MIN_SAMPLES_PER_SCL = 8;
  localparam int SAMPLES_PER_SCL = CLK_KHZ / SCL_FAST_PLUS_KHZ;

  // ==========================================================
  // pins as they arrive from the board
  typedef struct packed {
    logic scl;
    logic sda;
    logic select;
  } pins_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DEVADDR = 4'b0001,
    ST_DEVACK = 4'b0010,
    ST_REGADDR = 4'b0011,
    ST_REGACK = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_WACK = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RACK = 4'b1000,
    ST_IGNORE = 4'b1001
  } twi_state_t;
endpackage

// ---- verilog/pin_sync.sv ----
`timescale 1ns/10ps
`default_nettype none
module pin_sync
  import ecc_twi_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // asynchronous pins in, synchronised pins out
  input wire pins_t pins_i,
  output pins_t pins_o
);
  // ==========================================================
  // two-stage synchroniser; idle bus level is high
  pins_t meta;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta <= '1;
      pins_o <= '1;
    end else begin
      meta <= pins_i;
      pins_o <= meta;
    end
  end
endmodule
`default_nettype wire

// ---- verilog/ecc_register_two_wire_slave.sv ----
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - start: data falls while clock high; begins a transaction
// - a start anywhere aborts and rearms slave address decoding
// - stop: data rises while clock high; ends the transaction
// - data changes only while clock low, stable while high
// - bits launched on falling clock edge, captured on rising edge
// - every byte moves most significant bit first
// - ninth clock is acknowledge slot; receiver pulls data low
// - missing acknowledge aborts a write or ends a read, line released
// - read keeps sending next register while master acknowledges
// - written bytes only get acknowledge; read bytes either; data bytes after the first get none
// - slave address top four bits must match device type code
// - address bit 1 matches select pin; bits 3 and 2 ignored
// - address bit 0: one reads, zero writes
// - register address byte uses only its low three bits
// - writes carry register address; reads return data at once
// - write accepts eight data bits then acknowledges
// - all six registers readable over the serial link
// - internal address latch sources current-address reads
// - data pin is open-drain pull-low only; clock is input
// - works at fast and fast-plus bus clock rates
// - event output flags an ecc event occurrence
// - latch increments per acknowledged read byte, wraps five to zero
// - only setting register five is writable, single byte
// - event output stays high until clear bit written as one
// - random read: write header, repeated start, read address
module ecc_register_two_wire_slave
  import ecc_twi_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = 4'b1010  // arbitrary value
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // ecc engine event
  input wire logic ecc_event_i,
  // two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic device_select_pin_i,
  // event output, three-state
  output logic err_o,
  output logic err_oe_o
);
  // ==========================================================
  // elaboration checks; edge detect needs several samples per link bit
  if (SAMPLES_PER_SCL < MIN_SAMPLES_PER_SCL) begin : gen_rate_check
    $error("system clock too slow for fast-plus sampling");
  end

  // ==========================================================
  // pin synchronisers and edge detection
  pins_t pins_raw;
  pins_t pins_s;
  pins_t pins_d;

  assign pins_raw = '{scl: scl_i, sda: sda_i, select: device_select_pin_i};

  pin_sync u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .pins_i(pins_raw),
    .pins_o(pins_s)
  );

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pins_d <= '1;
    end else begin
      pins_d <= pins_s;
    end
  end

  wire scl_rise = pins_s.scl & ~pins_d.scl;
  wire scl_fall = ~pins_s.scl & pins_d.scl;
  wire scl_held = pins_s.scl & pins_d.scl;
  wire got_start = scl_held & pins_d.sda & ~pins_s.sda;
  wire got_stop = scl_held & ~pins_d.sda & pins_s.sda;

  // ==========================================================
  // register storage
  logic [7:0] ecc_event_info_reg;
  logic [7:0] loc_reg [1:4];
  logic [3:0] ecc_setting_reg;
  logic event_sticky;
  logic link_enable;
  logic [2:0] addr_latch;

  function automatic logic [7:0] reg_byte(input logic [2:0] idx,
                                          input logic [7:0] info,
                                          input logic [7:0] l1,
                                          input logic [7:0] l2,
                                          input logic [7:0] l3,
                                          input logic [7:0] l4,
                                          input logic [3:0] setting);
    case (idx)
      3'd0: reg_byte = info;
      3'd1: reg_byte = l1;
      3'd2: reg_byte = l2;
      3'd3: reg_byte = l3;
      3'd4: reg_byte = l4;
      REG_LAST: reg_byte = {4'h0, setting};
      default: reg_byte = 8'h00;
    endcase
  endfunction

  function automatic logic [2:0] next_addr(input logic [2:0] a);
    if (a >= REG_LAST) begin
      next_addr = REG_FIRST;
    end else begin
      next_addr = a + 3'd1;
    end
  endfunction

  // ==========================================================
  // two-wire state machine
  twi_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic pull_low;
  logic selected;
  logic rw_read;

  wire [7:0] cur_byte = reg_byte(addr_latch, ecc_event_info_reg,
                                 loc_reg[1], loc_reg[2], loc_reg[3],
                                 loc_reg[4], ecc_setting_reg);
  wire byte_in = (bit_cnt == BITS_PER_BYTE);
  wire type_ok = (shift[7:4] == DEV_TYPE);
  wire select_ok = (shift[1] == pins_s.select);
  wire addr_hit = type_ok & select_ok;
  wire setting_write = (state == ST_WDATA) & scl_fall & byte_in &
                       (addr_latch == REG_LAST);
  wire clear_req = setting_write & shift[SET_CLEAR];

  always_ff @(posedge clk_i) begin
    if (srst_i || !link_enable) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      pull_low <= 1'b0;
      selected <= 1'b0;
      rw_read <= 1'b0;
    end else if (got_start) begin
      state <= ST_DEVADDR;
      bit_cnt <= 4'h0;
      pull_low <= 1'b0;
      selected <= 1'b0;
    end else if (got_stop) begin
      state <= ST_IDLE;
      pull_low <= 1'b0;
      selected <= 1'b0;
    end else begin
      case (state)
        ST_DEVADDR, ST_REGADDR, ST_WDATA: begin
          if (scl_rise && !byte_in) begin
            shift <= {shift[6:0], pins_s.sda};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && byte_in) begin
            bit_cnt <= 4'h0;
            if (state == ST_DEVADDR) begin
              if (addr_hit) begin
                pull_low <= 1'b1;
                selected <= 1'b1;
                rw_read <= shift[0];
                state <= ST_DEVACK;
              end else begin
                state <= ST_IGNORE;
              end
            end else if (state == ST_REGADDR) begin
              pull_low <= 1'b1;
              state <= ST_REGACK;
            end else begin
              pull_low <= 1'b1;
              state <= ST_WACK;
            end
          end
        end
        ST_DEVACK: begin
          if (scl_fall) begin
            if (rw_read) begin
              shift <= cur_byte;
              pull_low <= ~cur_byte[7];
              bit_cnt <= 4'h0;
              state <= ST_RDATA;
            end else begin
              pull_low <= 1'b0;
              state <= ST_REGADDR;
            end
          end
        end
        ST_REGACK: begin
          if (scl_fall) begin
            pull_low <= 1'b0;
            state <= ST_WDATA;
          end
        end
        ST_WACK: begin
          if (scl_fall) begin
            pull_low <= 1'b0;
            state <= ST_IGNORE;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == BITS_PER_BYTE) begin
              pull_low <= 1'b0;
              state <= ST_RACK;
            end else begin
              shift <= {shift[6:0], 1'b0};
              pull_low <= ~shift[6];
            end
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            if (pins_s.sda) begin
              state <= ST_IGNORE;
            end
          end else if (scl_fall) begin
            shift <= cur_byte;
            pull_low <= ~cur_byte[7];
            bit_cnt <= 4'h0;
            state <= ST_RDATA;
          end
        end
        ST_IGNORE: begin
          pull_low <= 1'b0;
        end
        ST_IDLE: begin
          pull_low <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          pull_low <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // address latch
  wire reg_addr_done = (state == ST_REGADDR) & scl_fall & byte_in;
  wire read_acked = (state == ST_RACK) & scl_rise & ~pins_s.sda;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      addr_latch <= REG_FIRST;
    end else if (reg_addr_done) begin
      addr_latch <= shift[2:0];
    end else if (read_acked) begin
      addr_latch <= next_addr(addr_latch);
    end
  end

  // ==========================================================
  // setting register and sticky event
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ecc_setting_reg <= SETTING_RESET[3:0];
    end else if (setting_write) begin
      ecc_setting_reg <= shift[3:0] & SET_KEEP_MASK;
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      event_sticky <= 1'b0;
    end else if (ecc_event_i) begin
      event_sticky <= 1'b1;
    end else if (clear_req) begin
      event_sticky <= 1'b0;
    end
  end

  // ==========================================================
  // pin drivers
  wire err_enabled = ecc_setting_reg[SET_ECCON] &
                     ecc_setting_reg[SET_ERRON];

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      err_o <= 1'b0;
      err_oe_o <= 1'b0;
    end else begin
      err_o <= event_sticky;
      err_oe_o <= err_enabled;
    end
  end

  // open drain: only ever pulls low
  assign sda_o = 1'b0;
  assign sda_oe_o = pull_low;

  // ==========================================================
  // apb slave; read data captured in setup, answered in access
  wire apb_setup = psel_i & ~penable_i;
  wire apb_write = psel_i & penable_i & pwrite_i;
  wire addr_bad = (paddr_i[1:0] != 2'b00) | (paddr_i > OFF_LAST);
  wire is_loc = (paddr_i >= OFF_LOC1) & (paddr_i <= OFF_LOC4);
  wire [2:0] loc_idx = paddr_i[4:2];
  wire [7:0] status_byte = {2'b00, selected, addr_latch,
                            (state != ST_IDLE), event_sticky};

  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (paddr_i)
      OFF_EVENT_INFO: next_rdata = {24'h00_0000, ecc_event_info_reg};
      OFF_SETTING: next_rdata = {28'h000_0000, ecc_setting_reg};
      OFF_STATUS: next_rdata = {24'h00_0000, status_byte};
      OFF_CTRL: next_rdata = {31'h0000_0000, link_enable};
      default: begin
        if (is_loc) begin
          next_rdata = {24'h00_0000, loc_reg[loc_idx]};
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (apb_setup) begin
      prdata_o <= addr_bad ? 32'h0000_0000 : next_rdata;
    end
  end

  assign pready_o = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & addr_bad;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ecc_event_info_reg <= 8'h00;
      loc_reg[1] <= 8'h00;
      loc_reg[2] <= 8'h00;
      loc_reg[3] <= 8'h00;
      loc_reg[4] <= 8'h00;
      link_enable <= CTRL_RESET[CTRL_ENABLE];
    end else if (apb_write && !addr_bad) begin
      if (paddr_i == OFF_EVENT_INFO) begin
        ecc_event_info_reg <= pwdata_i[7:0];
      end
      if (is_loc) begin
        loc_reg[loc_idx] <= pwdata_i[7:0];
      end
      if (paddr_i == OFF_CTRL) begin
        link_enable <= pwdata_i[CTRL_ENABLE];
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/twi_slave_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module twi_slave_checker (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [7:0] paddr_i,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // pins
  input wire logic ecc_event_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic err_o,
  input wire logic err_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);
  // ==========================================================
  // properties
  pull_only_a: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  oe_rise_a: assert property ($rose(sda_oe_o) |-> !scl_i)
    else $error("data pulled while clock high");
  oe_fall_a: assert property ($fell(sda_oe_o) |-> !scl_i)
    else $error("data released while clock high");
  slot_hold_a: assert property ($rose(sda_oe_o) |=> sda_oe_o [*6])
    else $error("pull shorter than a bit");
  ready_now_a: assert property (pready_o == (psel_i && penable_i))
    else $error("ready not zero wait");
  bad_addr_a: assert property (pslverr_o == (psel_i && penable_i
    && (paddr_i > 8'h1C || paddr_i[1:0] != 2'b00)))
    else $error("slave error mismatch");
  event_set_a: assert property (ecc_event_i |-> ##[1:3] err_o)
    else $error("event not flagged");
  // an event just after the clear may raise the flag again
  event_keep_a: assert property ($fell(err_o)
    |-> !$past(ecc_event_i, 2))
    else $error("event flag lost");
  reset_out_a: assert property ($fell(srst_i)
    |-> !sda_oe_o && !err_o && !err_oe_o)
    else $error("outputs active after reset");
endmodule
bind ecc_register_two_wire_slave twi_slave_checker twi_slave_checker_inst (
  .clk_i(clk_i), .srst_i(srst_i), .psel_i(psel_i), .penable_i(penable_i),
  .paddr_i(paddr_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .ecc_event_i(ecc_event_i), .scl_i(scl_i), .sda_o(sda_o),
  .sda_oe_o(sda_oe_o), .err_o(err_o), .err_oe_o(err_oe_o));
`default_nettype wire

// ---- tb/host.sv ----
`timescale 1ns/10ps
`default_nettype none
module host (
  // clock and resolved data line
  input wire logic clk_i,
  input wire logic sda_i,
  // link clock and open-drain pull
  output logic scl_o,
  output logic sda_low_o
);
  // ==========================================================
  // bits: 8 clk per link clock, clock stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // sampled at the end of high, well after the device settles
  task automatic bit_x(input logic b, output logic s);
    tick(2);
    sda_low_o <= !b;
    tick(2);
    scl_o <= 1'b1;
    tick(4);
    s = sda_i;
    scl_o <= 1'b0;
  endtask
  // extra low time lets the device drop its pull first
  task automatic start();
    tick(4);
    sda_low_o <= 1'b0;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_low_o <= 1'b1;
    tick(2);
    scl_o <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    sda_low_o <= 1'b1;
    tick(2);
    scl_o <= 1'b1;
    tick(2);
    sda_low_o <= 1'b0;
    tick(4);
  endtask
  task automatic wr(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_x(b[i], s);
    bit_x(1'b1, s);
    ack = !s;
  endtask
  // the last byte wanted goes unacknowledged
  task automatic rd(input logic more, output logic [7:0] b);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bit_x(1'b1, s);
      b = {b[6:0], s};
    end
    bit_x(!more, s);
  endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
`timescale 1ns/10ps
`default_nettype none
module testbench import ecc_twi_pkg::*;;
  localparam logic [3:0] dev_type = 4'b0110; // arbitrary type code
  logic clk = 1'b0;
  logic srst, psel, penable, pwrite, pready, pslverr, ecc_event;
  logic select_pin, scl, sda, sda_o, sda_oe, mlow, err, err_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int bad_count = 0;
  int total_checks = 0;
  logic [7:0] val [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h03};
  always #20 clk = ~clk;
  // released line floats high on the pull-up
  assign sda = !(mlow || (sda_oe && !sda_o));
  ecc_register_two_wire_slave #(.DEV_TYPE(dev_type))
    ecc_register_two_wire_slave_inst (
    .clk_i(clk), .srst_i(srst), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .ecc_event_i(ecc_event), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .device_select_pin_i(select_pin), .err_o(err),
    .err_oe_o(err_oe));
  host host_inst (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(mlow));
  // ==========================================================
  // helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [7:0] sa(input logic rw);
    return {dev_type, 3'b001, rw};
  endfunction
  task automatic ser_write(input logic [7:0] ra, input logic [7:0] d);
    logic a0, a1, a2;
    host_inst.start();
    host_inst.wr(sa(1'b0), a0);
    host_inst.wr(ra, a1);
    host_inst.wr(d, a2);
    host_inst.stop();
    check({a0, a1, a2}, 3'b111);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_regs();
    logic [31:0] r;
    logic e;
    apb(1'b0, OFF_CTRL, 32'h0, r, e);
    check(r, CTRL_RESET);
    apb(1'b1, OFF_SETTING, 32'h0000_000F, r, e);
    apb(1'b0, OFF_SETTING, 32'h0, r, e);
    check(r, {24'h0, SETTING_RESET});
    apb(1'b0, 8'h22, 32'h0, r, e);
    check(r, 32'h0000_0000);
    check(e, 1'b1);
    for (int i = 0; i < 5; i++) apb(1'b1, 8'(4 * i), {24'h0, val[i]}, r, e);
  endtask
  task automatic t_write();
    logic [31:0] r;
    logic e;
    ser_write(8'hFD, 8'h03);
    apb(1'b0, OFF_SETTING, 32'h0, r, e);
    check(r, 32'h0000_0003);
    check({err_oe, err}, 2'b10);
  endtask
  task automatic t_event();
    ecc_event <= 1'b1;
    @(posedge clk);
    ecc_event <= 1'b0;
    repeat (4) @(posedge clk);
    check(err, 1'b1);
    ser_write(8'h02, 8'h99);
    check(err, 1'b1);
    ser_write(8'h05, 8'h13);
    repeat (4) @(posedge clk);
    check(err, 1'b0);
  endtask
  task automatic t_seq();
    logic a;
    host_inst.start();
    host_inst.wr(sa(1'b0), a);
    host_inst.wr(8'h02, a);
    host_inst.wr(8'h99, a);
    host_inst.wr(8'h77, a);
    host_inst.stop();
    check(a, 1'b0);
  endtask
  task automatic t_random();
    logic a;
    logic [7:0] b;
    host_inst.start();
    host_inst.wr(sa(1'b0), a);
    host_inst.wr(8'hF8, a);
    host_inst.start();
    host_inst.wr(sa(1'b1), a);
    check(a, 1'b1);
    for (int i = 0; i < 7; i++) begin
      host_inst.rd(i < 6, b);
      check(b, val[i % 6]);
    end
    host_inst.stop();
    check(sda_oe, 1'b0);
    host_inst.start();
    host_inst.wr(sa(1'b1), a);
    host_inst.rd(1'b0, b);
    host_inst.stop();
    check(b, val[0]);
  endtask
  task automatic t_mismatch();
    logic [9:0] tbl [4];
    logic a;
    logic [7:0] b;
    tbl = '{{2'b01, ~dev_type, 4'h3}, {2'b01, dev_type, 4'h1},
      {2'b11, dev_type, 4'hF}, {2'b10, dev_type, 4'h1}};
    for (int i = 0; i < 4; i++) begin
      select_pin <= tbl[i][8];
      host_inst.start();
      host_inst.wr(tbl[i][7:0], a);
      host_inst.rd(1'b0, b);
      host_inst.stop();
      check(a, tbl[i][9]);
      check(b, tbl[i][9] ? val[0] : 8'hFF);
    end
    select_pin <= 1'b1;
  endtask
  task automatic t_abort();
    logic a;
    logic [7:0] b;
    host_inst.start();
    host_inst.wr(sa(1'b0), a);
    host_inst.wr(8'h05, a);
    host_inst.bit_x(1'b1, a);
    host_inst.bit_x(1'b0, a);
    host_inst.start();
    host_inst.wr(sa(1'b1), a);
    host_inst.rd(1'b0, b);
    host_inst.stop();
    check({a, b}, {1'b1, val[5]});
  endtask
  // link disabled over apb, then enabled again; err pin switched off
  task automatic t_ctrl();
    logic [31:0] r;
    logic e, a;
    apb(1'b1, OFF_CTRL, 32'h0, r, e);
    host_inst.start();
    host_inst.wr(sa(1'b1), a);
    host_inst.stop();
    check(a, 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0, r, e);
    check(r, 32'(REG_LAST) << ST_LATCH_LO);
    apb(1'b1, OFF_CTRL, 32'h1, r, e);
    apb(1'b0, OFF_LOC2, 32'h0, r, e);
    check(r, {24'h0, val[2]});
    ser_write(8'h05, 8'h00);
    check({err_oe, err}, 2'b00);
  endtask
  initial begin
    #1_000_000;
    bad_count++;
    conclude();
  end
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ecc_event = 1'b0;
    select_pin = 1'b1;
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_write();
    t_event();
    t_seq();
    t_random();
    t_mismatch();
    t_abort();
    t_ctrl();
    conclude();
  end
endmodule
`default_nettype wire
